// ---- core/etxbc_top.sv ----
// Functional notes
// - on a request compare needed length with free space; flag space-now if room
// - no room and space irq enabled: wait for room, then set space event
// - commit only after good request and a read of a set space flag
// - committed region refuses data of any later frame
// - committed, written frame is sent unless a line failure flag rises
// - abort command discards the committed frame and any pending request unsent, except a request that a space-flag read commits in the abort cycle
// - underrun while underrun flag enabled cancels the committed frame
// - successful send sets the transmit-ok flag
// - sent length comes from written length, shaped by pad and crc bits
// - pad under 60 to 60; crc limit 1514, no-crc limit 1518
// - lengths below three bytes are never sent
// - link-good only after four consecutive valid link pulses
// - an invalid link pulse restarts the valid pulse count
// - no link pulses sent while automatic media select is active
// - bad length discards the command and sets bid error
// - transmit-ok with its irq enable raises the interrupt
`include "etxbc_consts.svh"
`timescale 1ns/1ps
`default_nettype none

module etxbc_top
    import etxbc_pkg::*;
#(
    parameter int NLP_CYCLES = `ETXBC_NLP_CYCLES
) (
    input  wire logic        clk_in,
    input  wire logic        srst_in,
    input  wire logic        cmd_wr_in,
    input  wire etxbc_cmd_t  cmd_in,
    input  wire logic        len_wr_in,
    input  wire logic [15:0] len_in,
    input  wire logic        bus_status_rd_in,
    input  wire logic        buf_event_rd_in,
    input  wire logic        tx_event_rd_in,
    input  wire logic        tx_space_irq_en_in,
    input  wire logic        tx_done_irq_en_in,
    input  wire logic        underrun_en_in,
    input  wire logic        wr_valid_in,
    input  wire logic [7:0]  wr_data_in,
    output logic             wr_ready_out,
    output logic             line_valid_out,
    output logic [7:0]       line_data_out,
    input  wire logic        line_ready_in,
    output logic             line_start_out,
    output logic [15:0]      frame_len_out,
    output logic             crc_append_out,
    input  wire logic        line_done_in,
    input  wire etxbc_fail_t line_fail_in,
    input  wire logic        tx_underrun_in,
    input  wire logic        nlp_valid_in,
    input  wire logic        nlp_invalid_in,
    input  wire logic        auto_select_in,
    output logic             tx_space_now_out,
    output logic             tx_space_event_out,
    output logic             tx_bid_error_out,
    output logic             tx_done_ok_out,
    output etxbc_fail_t      fail_flags_out,
    output logic             tx_irq_out,
    output logic             committed_out,
    output logic [15:0]      free_space_out,
    output logic             link_good_out,
    output logic             link_pulse_out
);

    function automatic logic len_ok(input logic [15:0] len,
                                    input logic        crc_sup);
        len_ok = (len >= `ETXBC_LEN_MIN) &&
                 (len <= (crc_sup ? `ETXBC_MAX_NO_CRC
                                  : `ETXBC_MAX_WITH_CRC));
    endfunction : len_ok

    function automatic logic [15:0] wire_len(input logic [15:0] len,
                                             input etxbc_cmd_t  cmd);
        logic [15:0] padded;
        padded = (!cmd.pad_disable && len < `ETXBC_PAD_LEN) ?
                 `ETXBC_PAD_LEN : len;
        wire_len = padded + (cmd.crc_suppress ? 16'h0000
                                              : `ETXBC_CRC_BYTES);
    endfunction : wire_len

    etxbc_state_t state_r;
    etxbc_state_t state_nxt;
    etxbc_cmd_t   cmd_r;
    etxbc_fail_t  fail_r;
    logic [15:0]  len_r;
    logic [15:0]  need_r;
    logic [15:0]  free_r;
    logic [15:0]  left_r;
    logic         space_now_r;
    logic         space_event_r;
    logic         bid_err_r;
    logic         done_ok_r;
    logic         irq_r;
    logic         start_r;
    logic         wr_open_r;
    logic [2:0]   nlp_cnt_r;
    logic         link_good_r;
    logic [31:0]  nlp_div_r;
    logic         link_pulse_r;
    logic         fifo_in_ready;
    logic         fifo_push;

    // decode of the current request and of the frame's end events
    wire busy      = state_r[4] || state_r[5];
    wire abort_cmd = cmd_wr_in && cmd_in.abort;
    wire new_cmd   = cmd_wr_in && !cmd_in.abort && !busy;
    wire len_take  = len_wr_in && (state_r == ST_WLEN);
    wire len_good  = len_ok(len_in, cmd_r.crc_suppress);
    wire [15:0] need_now = wire_len(len_in, cmd_r);
    wire room_now  = (free_r >= need_now);
    wire room_wait = (free_r >= need_r);
    wire commit    = (state_r == ST_READY) &&
                     ((bus_status_rd_in && space_now_r) ||
                      (buf_event_rd_in && space_event_r));
    wire any_fail  = |line_fail_in;
    wire underrun  = busy && tx_underrun_in && underrun_en_in;
    wire sent_ok   = (state_r == ST_SEND) && line_done_in && !any_fail;
    wire failed    = (state_r == ST_SEND) && any_fail;
    wire release_s = busy && (abort_cmd || underrun || sent_ok || failed);
    wire flush     = abort_cmd || underrun || failed;
    wire last_byte = fifo_push && (left_r == 16'h0001);

    assign fifo_push = wr_valid_in && wr_open_r && fifo_in_ready;

    always_comb begin
        state_nxt = state_r;
        unique case (state_r)
            ST_IDLE:  if (new_cmd) state_nxt = ST_WLEN;
            ST_WLEN: begin
                if (len_take) begin
                    if (!len_good) begin
                        state_nxt = ST_IDLE;
                    end else if (room_now) begin
                        state_nxt = ST_READY;
                    end else begin
                        state_nxt = ST_WSPC;
                    end
                end
            end
            ST_WSPC:  if (room_wait) state_nxt = ST_READY;
            ST_READY: if (commit) state_nxt = ST_FILL;
            ST_FILL:  if (last_byte) state_nxt = ST_SEND;
            ST_SEND:  if (sent_ok || failed) state_nxt = ST_IDLE;
        endcase
        if (abort_cmd || underrun) begin
            state_nxt = ST_IDLE;
        end
    end

    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            state_r <= ST_IDLE;
        end else begin
            state_r <= state_nxt;
        end
    end

    // request capture; the length drives the shaped wire length
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            cmd_r  <= '0;
            len_r  <= 16'h0000;
            need_r <= 16'h0000;
        end else begin
            if (new_cmd) begin
                cmd_r <= cmd_in;
            end
            if (len_take && len_good) begin
                len_r  <= len_in;
                need_r <= need_now;
            end
        end
    end

    // free pool: one subtract at commit, one give-back at release
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            free_r <= `ETXBC_BUF_BYTES;
        end else if (commit) begin
            free_r <= free_r - need_r;
        end else if (release_s) begin
            free_r <= free_r + need_r;
        end
    end

    // write window stays shut once the committed frame is complete
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            left_r    <= 16'h0000;
            wr_open_r <= 1'b0;
        end else if (commit) begin
            left_r    <= len_r;
            wr_open_r <= 1'b1;
        end else if (flush || last_byte) begin
            left_r    <= 16'h0000;
            wr_open_r <= 1'b0;
        end else if (fifo_push) begin
            left_r <= left_r - 16'h0001;
        end
    end

    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            start_r        <= 1'b0;
            frame_len_out  <= 16'h0000;
            crc_append_out <= 1'b0;
        end else begin
            start_r <= commit;
            if (commit) begin
                frame_len_out  <= need_r;
                crc_append_out <= !cmd_r.crc_suppress;
            end
        end
    end

    // status flags: a set in the same cycle as a clearing read wins
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            space_now_r   <= 1'b0;
            space_event_r <= 1'b0;
            bid_err_r     <= 1'b0;
        end else begin
            if (len_take && len_good && room_now) begin
                space_now_r <= 1'b1;
            end else if (state_r == ST_WSPC && room_wait) begin
                space_now_r <= 1'b1;
            end else if (commit || flush) begin
                space_now_r <= 1'b0;
            end
            if (state_r == ST_WSPC && room_wait && tx_space_irq_en_in) begin
                space_event_r <= 1'b1;
            end else if (buf_event_rd_in || flush) begin
                space_event_r <= 1'b0;
            end
            if (len_take && !len_good) begin
                bid_err_r <= 1'b1;
            end else if (bus_status_rd_in) begin
                bid_err_r <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            done_ok_r <= 1'b0;
            fail_r    <= '0;
            irq_r     <= 1'b0;
        end else begin
            if (sent_ok) begin
                done_ok_r <= 1'b1;
            end else if (tx_event_rd_in) begin
                done_ok_r <= 1'b0;
            end
            if (failed) begin
                fail_r <= fail_r | line_fail_in;
            end else if (tx_event_rd_in) begin
                fail_r <= '0;
            end
            irq_r <= (done_ok_r && tx_done_irq_en_in) ||
                     (space_event_r && tx_space_irq_en_in);
        end
    end

    // link qualification against the hub
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            nlp_cnt_r   <= 3'h0;
            link_good_r <= 1'b0;
        end else if (nlp_invalid_in) begin
            nlp_cnt_r   <= 3'h0;
            link_good_r <= 1'b0;
        end else if (nlp_valid_in && nlp_cnt_r != `ETXBC_LINK_GOOD_CNT) begin
            nlp_cnt_r   <= nlp_cnt_r + 3'h1;
            link_good_r <= (nlp_cnt_r + 3'h1 == `ETXBC_LINK_GOOD_CNT);
        end
    end

    // the divider keeps running under auto select so pulses resume in phase
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            nlp_div_r    <= 32'h00000000;
            link_pulse_r <= 1'b0;
        end else begin
            if (nlp_div_r == 32'(NLP_CYCLES - 1)) begin
                nlp_div_r <= 32'h00000000;
            end else begin
                nlp_div_r <= nlp_div_r + 32'h00000001;
            end
            link_pulse_r <= (nlp_div_r == 32'(NLP_CYCLES - 1)) &&
                            !auto_select_in;
        end
    end

    etxbc_fifo #(
        .WIDTH (`ETXBC_FIFO_WIDTH),
        .DEPTH (`ETXBC_FIFO_DEPTH)
    ) u_fifo (
        .clk_in        (clk_in),
        .srst_in       (srst_in),
        .flush_in      (flush),
        .in_valid_in   (wr_valid_in && wr_open_r),
        .in_data_in    (wr_data_in),
        .in_ready_out  (fifo_in_ready),
        .out_valid_out (line_valid_out),
        .out_data_out  (line_data_out),
        .out_ready_in  (line_ready_in)
    );

    // ready is gated by the commit window; a wire, not a fresh flop
    assign wr_ready_out       = fifo_in_ready && wr_open_r;
    assign line_start_out     = start_r;
    assign tx_space_now_out   = space_now_r;
    assign tx_space_event_out = space_event_r;
    assign tx_bid_error_out   = bid_err_r;
    assign tx_done_ok_out     = done_ok_r;
    assign fail_flags_out     = fail_r;
    assign tx_irq_out         = irq_r;
    assign committed_out      = busy;
    assign free_space_out     = free_r;
    assign link_good_out      = link_good_r;
    assign link_pulse_out     = link_pulse_r;

    default clocking cb @(posedge clk_in); endclocking
    default disable iff (srst_in);

    commit_needs_flag_a: assert property (
        $rose(busy) |-> $past(space_now_r || space_event_r))
        else $error("space committed without a set space flag");

    bad_len_err_a: assert property (
        len_take && !len_good |=> bid_err_r && state_r == ST_IDLE)
        else $error("bad length did not raise bid error");

    short_len_a: assert property (
        len_take && len_in < `ETXBC_LEN_MIN |=> !space_now_r)
        else $error("frame under three bytes accepted");

    write_window_a: assert property (
        fifo_push |-> state_r == ST_FILL)
        else $error("data taken outside committed region");

    abort_flush_a: assert property (
        abort_cmd && busy |=> !line_valid_out && state_r == ST_IDLE
                              && free_r == $past(free_r) + $past(need_r))
        else $error("abort left frame data or space behind");

    underrun_cancel_a: assert property (
        underrun |=> state_r == ST_IDLE && !wr_open_r)
        else $error("underrun did not cancel frame");

    done_ok_set_a: assert property (
        sent_ok |=> done_ok_r ##1 irq_r || !tx_done_irq_en_in)
        else $error("transmit ok or its interrupt missing");

    pad_len_a: assert property (
        commit && !cmd_r.pad_disable |=> frame_len_out >= `ETXBC_PAD_LEN)
        else $error("short frame not padded");

    link_qual_a: assert property (
        $rose(link_good_r) |-> $past(nlp_cnt_r) == 3'h3)
        else $error("link good before four valid pulses");

    invalid_reset_a: assert property (
        nlp_invalid_in |=> nlp_cnt_r == 3'h0 && !link_good_r)
        else $error("invalid pulse did not restart count");

    no_pulse_auto_a: assert property (
        $past(auto_select_in) |-> !link_pulse_r)
        else $error("link pulse sent in auto select");

    cover_sent_c:   cover property (commit ##[1:200] sent_ok);
    cover_wait_c:   cover property (state_r == ST_WSPC ##[1:300] commit);
    cover_abort_c:  cover property (busy && abort_cmd);
    cover_link_c:   cover property ($rose(link_good_r));

endmodule : etxbc_top

`default_nettype wire

// ---- core/etxbc_consts.svh ----
`ifndef ETXBC_CONSTS_SVH
`define ETXBC_CONSTS_SVH

// frame length limits, in bytes
`define ETXBC_LEN_MIN        16'h0003
`define ETXBC_PAD_LEN        16'h003C
`define ETXBC_MAX_WITH_CRC   16'h05EA
`define ETXBC_MAX_NO_CRC     16'h05EE
`define ETXBC_CRC_BYTES      16'h0004

// on-chip transmit buffer size in bytes
`define ETXBC_BUF_BYTES      16'h0C00

// consecutive valid link pulses needed for link-good
`define ETXBC_LINK_GOOD_CNT  3'h4

// link pulse spacing
`define ETXBC_NLP_PERIOD_NS  16000000
`define ETXBC_CLK_PERIOD_NS  10
`define ETXBC_NLP_CYCLES     (`ETXBC_NLP_PERIOD_NS / `ETXBC_CLK_PERIOD_NS)

// data buffer shape
`define ETXBC_FIFO_WIDTH     8
`define ETXBC_FIFO_DEPTH     16

`endif

// ---- core/etxbc_pkg.sv ----
package etxbc_pkg;

    typedef enum logic [5:0] {
        ST_IDLE  = 6'h01,
        ST_WLEN  = 6'h02,
        ST_WSPC  = 6'h04,
        ST_READY = 6'h08,
        ST_FILL  = 6'h10,
        ST_SEND  = 6'h20
    } etxbc_state_t;

    typedef struct packed {
        logic abort;
        logic pad_disable;
        logic crc_suppress;
    } etxbc_cmd_t;

    typedef struct packed {
        logic excess_collision;
        logic jabber;
        logic late_collision;
    } etxbc_fail_t;

endpackage : etxbc_pkg

// ---- core/etxbc_fifo.sv ----
`timescale 1ns/1ps
`default_nettype none

module etxbc_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16
) (
    input  wire logic             clk_in,
    input  wire logic             srst_in,
    input  wire logic             flush_in,
    input  wire logic             in_valid_in,
    input  wire logic [WIDTH-1:0] in_data_in,
    output logic                  in_ready_out,
    output logic                  out_valid_out,
    output logic [WIDTH-1:0]      out_data_out,
    input  wire logic             out_ready_in
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem_r [DEPTH];
    logic [AW-1:0]    wr_ptr_r;
    logic [AW-1:0]    rd_ptr_r;
    logic [AW:0]      count_r;
    logic [AW:0]      count_nxt;
    logic             in_ready_r;
    logic             out_valid_r;
    logic [WIDTH-1:0] out_data_r;

    wire push = in_valid_in && in_ready_r;
    wire pop  = (count_r != '0) && (!out_valid_r || out_ready_in);

    assign count_nxt = count_r + (AW+1)'(push) - (AW+1)'(pop);

    always_ff @(posedge clk_in) begin
        if (push) begin
            mem_r[wr_ptr_r] <= in_data_in;
        end
    end

    always_ff @(posedge clk_in) begin
        if (srst_in || flush_in) begin
            wr_ptr_r    <= '0;
            rd_ptr_r    <= '0;
            count_r     <= '0;
            in_ready_r  <= 1'b1;
            out_valid_r <= 1'b0;
            out_data_r  <= '0;
        end else begin
            wr_ptr_r   <= wr_ptr_r + AW'(push);
            rd_ptr_r   <= rd_ptr_r + AW'(pop);
            count_r    <= count_nxt;
            // full is registered so the writer sees back-pressure cleanly
            in_ready_r <= (count_nxt != (AW+1)'(DEPTH));
            if (pop) begin
                out_valid_r <= 1'b1;
                out_data_r  <= mem_r[rd_ptr_r];
            end else if (out_ready_in) begin
                out_valid_r <= 1'b0;
            end
        end
    end

    assign in_ready_out  = in_ready_r;
    assign out_valid_out = out_valid_r;
    assign out_data_out  = out_data_r;

endmodule : etxbc_fifo

`default_nettype wire

// ---- dv/etxbc_line_model.sv ----
`timescale 1ns/1ps
`default_nettype none

module etxbc_line_model (
    input  wire logic        clk_in,
    input  wire logic        srst_in,
    input  wire logic        slow_in,
    input  wire logic [15:0] nbytes_in,
    input  wire logic        line_start_in,
    input  wire logic        line_valid_in,
    input  wire logic [7:0]  line_data_in,
    output logic             line_ready_out,
    output logic             line_done_out,
    output logic [15:0]      byte_cnt_out,
    output logic             order_bad_out
);
    logic stall_r;
    wire  take = line_valid_in && line_ready_out;
    // a slow mac stalls every other cycle so the fifo backs up
    assign line_ready_out = !(slow_in && stall_r);
    always_ff @(posedge clk_in) begin
        if (srst_in || line_start_in) begin
            stall_r       <= 1'b0;
            byte_cnt_out  <= 16'h0000;
            line_done_out <= 1'b0;
            order_bad_out <= 1'b0;
        end else begin
            stall_r       <= ~stall_r;
            line_done_out <= take && (byte_cnt_out + 16'h0001 == nbytes_in);
            if (take) begin
                byte_cnt_out <= byte_cnt_out + 16'h0001;
                if (line_data_in !== byte_cnt_out[7:0])
                    order_bad_out <= 1'b1;
            end
        end
    end
endmodule : etxbc_line_model

`default_nettype wire

// ---- dv/etxbc_top_tb.sv ----
`timescale 1ns/1ps
`default_nettype none

module etxbc_top_tb;
    import etxbc_pkg::*;
    typedef struct {
        logic [15:0] len;
        logic        pd;
        logic        cs;
        logic        bad;
        logic [15:0] wl;
    } etxbc_row_t;
    localparam int NLP = 20;
    logic clk_in = 1'b0, srst_in = 1'b1, cmd_wr_in = 1'b0, len_wr_in = 1'b0;
    logic bus_status_rd_in = 1'b0, buf_event_rd_in = 1'b0;
    logic tx_event_rd_in = 1'b0, tx_space_irq_en_in = 1'b1;
    logic tx_done_irq_en_in = 1'b1, underrun_en_in = 1'b0, wr_valid_in = 1'b0;
    logic tx_underrun_in = 1'b0, nlp_valid_in = 1'b0, nlp_invalid_in = 1'b0;
    logic auto_select_in = 1'b0, slow = 1'b0, order_bad;
    logic wr_ready_out, line_valid_out, line_ready_in, line_start_out;
    logic crc_append_out, line_done_in, tx_space_now_out, tx_space_event_out;
    logic tx_bid_error_out, tx_done_ok_out, tx_irq_out, committed_out;
    logic link_good_out, link_pulse_out;
    logic [7:0]  wr_data_in = 8'h00, line_data_out;
    logic [15:0] len_in = 16'h0000, nbytes = 16'h0000, byte_cnt;
    logic [15:0] frame_len_out, free_space_out, npulse;
    etxbc_cmd_t  cmd_in = '0;
    etxbc_fail_t line_fail_in = '0, fail_flags_out;
    int mismatches = 0, compares = 0, cyc = 0;
    etxbc_row_t rows [10] = '{
        '{16'h0002, 1'b0, 1'b0, 1'b1, 16'h0000},
        '{16'h0003, 1'b0, 1'b0, 1'b0, 16'h0040},
        '{16'h003B, 1'b1, 1'b0, 1'b0, 16'h003F},
        '{16'h003B, 1'b0, 1'b1, 1'b0, 16'h003C},
        '{16'h003C, 1'b0, 1'b0, 1'b0, 16'h0040},
        '{16'h05EA, 1'b0, 1'b0, 1'b0, 16'h05EE},
        '{16'h05EB, 1'b0, 1'b0, 1'b1, 16'h0000},
        '{16'h05EB, 1'b0, 1'b1, 1'b0, 16'h05EB},
        '{16'h05EE, 1'b1, 1'b1, 1'b0, 16'h05EE},
        '{16'h05EF, 1'b0, 1'b1, 1'b1, 16'h0000}};

    etxbc_top #(.NLP_CYCLES(NLP)) dut_u (
        .clk_in, .srst_in, .cmd_wr_in, .cmd_in, .len_wr_in, .len_in,
        .bus_status_rd_in, .buf_event_rd_in, .tx_event_rd_in,
        .tx_space_irq_en_in, .tx_done_irq_en_in, .underrun_en_in,
        .wr_valid_in, .wr_data_in, .wr_ready_out, .line_valid_out,
        .line_data_out, .line_ready_in, .line_start_out, .frame_len_out,
        .crc_append_out, .line_done_in, .line_fail_in, .tx_underrun_in,
        .nlp_valid_in, .nlp_invalid_in, .auto_select_in, .tx_space_now_out,
        .tx_space_event_out, .tx_bid_error_out, .tx_done_ok_out,
        .fail_flags_out, .tx_irq_out, .committed_out, .free_space_out,
        .link_good_out, .link_pulse_out);

    etxbc_line_model model_u (
        .clk_in, .srst_in, .slow_in(slow), .nbytes_in(nbytes),
        .line_start_in(line_start_out), .line_valid_in(line_valid_out),
        .line_data_in(line_data_out), .line_ready_out(line_ready_in),
        .line_done_out(line_done_in), .byte_cnt_out(byte_cnt),
        .order_bad_out(order_bad));

    initial begin
        forever #5 clk_in = ~clk_in;
    end

    task automatic complete_run();
        $display("compares %0d mismatches %0d", compares, mismatches);
        if (mismatches == 0 && compares > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : complete_run

    task automatic chk1(input string nm, input logic e, input logic g);
        compares++;
        if (g !== e) begin
            mismatches++;
            $display("[ERR] %s exp %b got %b", nm, e, g);
        end
    endtask : chk1

    task automatic chk16(input string nm, input logic [15:0] e,
                         input logic [15:0] g);
        compares++;
        if (g !== e) begin
            mismatches++;
            $display("[ERR] %s exp %h got %h", nm, e, g);
        end
    endtask : chk16

    task automatic tick(input int n);
        repeat (n) @(negedge clk_in);
    endtask : tick

    task automatic bid(input logic ab, input logic pd, input logic cs,
                       input logic [15:0] l);
        cmd_wr_in = 1'b1;
        cmd_in    = {ab, pd, cs};
        tick(1);
        cmd_wr_in = 1'b0;
        len_wr_in = 1'b1;
        len_in    = l;
        tick(1);
        len_wr_in = 1'b0;
        tick(1);
    endtask : bid

    task automatic read_status();
        bus_status_rd_in = 1'b1;
        tick(1);
        bus_status_rd_in = 1'b0;
    endtask : read_status

    task automatic open_frame(input logic pd, input logic cs,
                              input logic [15:0] l, input logic [15:0] wl);
        bid(1'b0, pd, cs, l);
        chk1("space_now", 1'b1, tx_space_now_out);
        chk16("free_before", 16'h0C00, free_space_out);
        read_status();
        chk1("committed", 1'b1, committed_out);
        chk16("free_held", 16'h0C00 - wl, free_space_out);
        chk1("line_start", 1'b1, line_start_out);
        tick(1);
        chk16("frame_len", wl, frame_len_out);
        chk1("crc_append", ~cs, crc_append_out);
    endtask : open_frame

    task automatic send_bytes(input int n);
        int i;
        i = 0;
        while (i < n) begin
            wr_valid_in = 1'b1;
            wr_data_in  = i[7:0];
            if (wr_ready_out === 1'b1)
                i++;
            tick(1);
        end
        wr_valid_in = 1'b0;
    endtask : send_bytes

    task automatic clear_events();
        tx_event_rd_in = 1'b1;
        tick(1);
        tx_event_rd_in = 1'b0;
        tick(1);
        chk1("done_clr", 1'b0, tx_done_ok_out);
        chk16("fail_clr", 16'h0000, 16'(fail_flags_out));
    endtask : clear_events

    initial begin
        forever begin
            @(posedge clk_in);
            cyc++;
            // generous ceiling: the long rows take about 7600 cycles
            if (cyc == 40000) begin
                mismatches++;
                $display("[ERR] run_time exp below 40000 got 40000");
                complete_run();
            end
        end
    end

    initial begin
        tick(12);
        srst_in = 1'b0;
        chk16("free_reset", 16'h0C00, free_space_out);
        chk1("link_reset", 1'b0, link_good_out);
        chk1("ready_reset", 1'b0, wr_ready_out);
        $display("test reset done");
        for (int r = 0; r < 10; r++) begin
            nbytes = rows[r].len;
            slow   = r[0];
            if (rows[r].bad) begin
                bid(1'b0, rows[r].pd, rows[r].cs, rows[r].len);
                chk1("bid_error", 1'b1, tx_bid_error_out);
                chk1("space_bad", 1'b0, tx_space_now_out);
                read_status();
                tick(1);
                chk1("bid_clr", 1'b0, tx_bid_error_out);
                chk1("no_commit", 1'b0, committed_out);
            end else begin
                open_frame(rows[r].pd, rows[r].cs, rows[r].len, rows[r].wl);
                send_bytes(rows[r].len);
                chk1("window_shut", 1'b0, wr_ready_out);
                for (int k = 0; k < 4000 && tx_done_ok_out !== 1'b1; k++)
                    tick(1);
                chk1("done_ok", 1'b1, tx_done_ok_out);
                chk16("free_back", 16'h0C00, free_space_out);
                chk16("bytes_sent", rows[r].len, byte_cnt);
                chk1("byte_order", 1'b0, order_bad);
                tick(1);
                chk1("done_irq", 1'b1, tx_irq_out);
                clear_events();
            end
            $display("test row %0d done", r);
        end
        nbytes = 16'h0064;
        bid(1'b0, 1'b0, 1'b0, 16'h0064);
        tick(3);
        chk1("wait_read", 1'b0, committed_out);
        read_status();
        send_bytes(20);
        bid(1'b1, 1'b0, 1'b0, 16'h0000);
        chk1("abort_idle", 1'b0, committed_out);
        chk16("abort_free", 16'h0C00, free_space_out);
        tick(5);
        chk1("abort_flush", 1'b0, line_valid_out);
        chk1("abort_nodone", 1'b0, tx_done_ok_out);
        $display("test abort done");
        open_frame(1'b0, 1'b0, 16'h0064, 16'h0068);
        for (int u = 0; u < 2; u++) begin
            underrun_en_in = u[0];
            tx_underrun_in = 1'b1;
            tick(1);
            tx_underrun_in = 1'b0;
            tick(1);
            chk1("underrun", ~u[0], committed_out);
        end
        chk16("underrun_free", 16'h0C00, free_space_out);
        underrun_en_in = 1'b0;
        $display("test underrun done");
        nbytes = 16'hFFFF;
        for (int f = 0; f < 3; f++) begin
            open_frame(1'b0, 1'b0, 16'h0064, 16'h0068);
            send_bytes(100);
            tick(20);
            line_fail_in = 3'(1 << f);
            tick(1);
            line_fail_in = '0;
            tick(1);
            chk16("fail_kind", 16'h0001 << f, 16'(fail_flags_out));
            chk1("fail_idle", 1'b0, committed_out);
            chk1("fail_nodone", 1'b0, tx_done_ok_out);
            chk16("fail_free", 16'h0C00, free_space_out);
            clear_events();
        end
        $display("test line_fail done");
        for (int p = 0; p < 8; p++) begin
            if (p == 3)
                nlp_invalid_in = 1'b1;
            else
                nlp_valid_in = 1'b1;
            tick(1);
            nlp_valid_in   = 1'b0;
            nlp_invalid_in = 1'b0;
            tick(1);
            if (p == 2 || p == 6)
                chk1("link_early", 1'b0, link_good_out);
        end
        chk1("link_good", 1'b1, link_good_out);
        auto_select_in = 1'b1;
        npulse = 16'h0000;
        for (int c = 0; c < 3 * NLP; c++) begin
            tick(1);
            if (link_pulse_out === 1'b1)
                npulse++;
        end
        chk16("muted_pulses", 16'h0000, npulse);
        auto_select_in = 1'b0;
        npulse = 16'h0000;
        for (int c = 0; c < NLP + 2; c++) begin
            tick(1);
            if (link_pulse_out === 1'b1)
                npulse++;
        end
        chk1("pulse_back", 1'b1, npulse != 16'h0000);
        $display("test link done");
        complete_run();
    end
endmodule : etxbc_top_tb

`default_nettype wire
